// *** hw/ccpr_pkg.sv ***
package ccpr_pkg;
  // register offsets (12-bit serial address)
  localparam logic [11:0] CCPR_OFF_SOFT_RESET = 12'h000;
  localparam logic [11:0] CCPR_OFF_IFACE = 12'h007;
  localparam logic [11:0] CCPR_OFF_PDN = 12'h008;
  localparam logic [11:0] CCPR_OFF_OBD_LO = 12'h00a;
  localparam logic [11:0] CCPR_OFF_OBD_MID = 12'h00b;
  localparam logic [11:0] CCPR_OFF_OBD_HI = 12'h00c;
  localparam logic [11:0] CCPR_OFF_MASK = 12'h00d;
  localparam logic [11:0] CCPR_OFF_FUSE = 12'h013;
  // field positions
  localparam int CCPR_BIT_RESET = 0;
  localparam int CCPR_BIT_MAP_HI = 7;
  localparam int CCPR_BIT_MAP_LO = 5;
  localparam int CCPR_BIT_OVR = 3;
  localparam int CCPR_BIT_SEL_HI = 2;
  localparam int CCPR_BIT_CLKBUF = 5;
  localparam int CCPR_BIT_REFAMP = 4;
  localparam int CCPR_BIT_CHA = 2;
  localparam int CCPR_BIT_CHB = 1;
  localparam int CCPR_BIT_GLOBAL = 0;
  localparam int CCPR_BIT_KEEP_CLK = 3;
  localparam int CCPR_BIT_KEEP_REF = 2;
  localparam int CCPR_BIT_BG_OFF = 1;
  localparam int CCPR_BIT_FUSE_LD = 0;
  // writable-bit masks; reserved bits read as zero
  localparam logic [7:0] CCPR_MASK_SOFT_RESET = 8'h01;
  localparam logic [7:0] CCPR_MASK_IFACE = 8'hef;
  localparam logic [7:0] CCPR_MASK_PDN = 8'h37;
  localparam logic [7:0] CCPR_MASK_MASKREG = 8'h0e;
  // reset values
  localparam logic [7:0] CCPR_RST_BYTE = 8'h00;
  localparam logic [23:0] CCPR_RST_OBD = 24'h000000;
  // serial frame: r/w bit, 3 zero bits, 12 address bits, 8 data bits
  localparam logic [4:0] CCPR_FRAME_BITS = 5'h18;
  localparam logic [4:0] CCPR_ADDR_BITS = 5'h10;
  // interface mapper codes
  localparam logic [2:0] CCPR_MAP_2W_18_14 = 3'h1;
  localparam logic [2:0] CCPR_MAP_2W_16 = 3'h2;
  localparam logic [2:0] CCPR_MAP_1W = 3'h3;
  localparam logic [2:0] CCPR_MAP_HALF = 3'h4;
  localparam logic [2:0] CCPR_MAP_DDR = 3'h5;
  // interface mode codes
  localparam logic [2:0] CCPR_MODE_DDR = 3'h1;
  localparam logic [2:0] CCPR_MODE_2W = 3'h3;
  localparam logic [2:0] CCPR_MODE_1W = 3'h4;
  localparam logic [2:0] CCPR_MODE_HALF = 3'h5;
endpackage : ccpr_pkg

// *** hw/ccpr_serial_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for the serial pins
module ccpr_serial_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pin side
  input wire logic [2:0] pin_in,
  // synchronised side
  output logic [2:0] sync_out
);
  logic [2:0] meta_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // idle pin levels: select high, sclk low, so no false sclk edge after reset
      meta_reg <= 3'h4;
      sync_out <= 3'h4;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end
endmodule : ccpr_serial_sync
`default_nettype wire

// *** hw/ccpr_regs.sv ***
// Function
// - bit 0 at 0x00 resets all registers
// - mapper field bits 7-5 codes 001..101
// - mapper takes effect after fuse load
// - fuse mapping used, field reads 000
// - bit 3 enables interface mode override
// - mode field bits 2-0 codes DDR..half
// - fuse mode used, bit 3 reads 0
// - bit 5 powers down clock buffer
// - bit 4 powers down reference amplifier
// - bit 2 powers down channel A
// - bit 1 powers down channel B
// - bit 0 global power-down, mask decides clock/ref/bandgap
// - 24-bit field disables output buffers
// - mask bit keeps clock/ref powered
`timescale 1ns/1ns
`default_nettype none
module ccpr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial port pins, host-clocked, sampled here
  input wire logic serial_port_select_n,
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // fuse defaults
  input wire logic [2:0] fuse_bit_mapping,
  input wire logic [2:0] fuse_iface_mode,
  // effective interface settings
  output logic [2:0] iface_bit_mapping,
  output logic [2:0] iface_mode_select,
  // power controls
  output logic sample_clock_buffer_off,
  output logic reference_gain_amp_off,
  output logic channel_a_off,
  output logic channel_b_off,
  output logic bandgap_off,
  output logic [23:0] output_buffer_disable
);
  import ccpr_pkg::*;

  typedef enum logic [1:0] {CCPR_IDLE, CCPR_SHIFT, CCPR_DONE} ccpr_state_t;

  logic [2:0] sync;
  logic sen_n;
  logic sclk_s;
  logic sdi_s;
  logic sclk_d_reg;
  logic rise;
  logic fall;
  ccpr_state_t state_reg;
  logic [4:0] cnt_reg;
  logic [23:0] shift_reg;
  logic [7:0] rdata_reg;
  logic soft_rst;
  logic wr_stb;
  logic [7:0] soft_reset_ctrl_reg;
  logic [7:0] output_interface_ctrl_reg;
  logic [7:0] power_down_ctrl_reg;
  logic [23:0] obd_reg;
  logic [7:0] mask_reg;
  logic [2:0] map_active_reg;
  logic [2:0] mode_fuse_reg;
  logic [7:0] rd_byte;

  function automatic logic [7:0] ccpr_read(input logic [11:0] a, input logic [7:0] rst, input logic [7:0] ifc,
                                          input logic [7:0] pdn, input logic [23:0] obd, input logic [7:0] msk);
    case (a)
      CCPR_OFF_SOFT_RESET: ccpr_read = rst;
      CCPR_OFF_IFACE: ccpr_read = ifc;
      CCPR_OFF_PDN: ccpr_read = pdn;
      CCPR_OFF_OBD_LO: ccpr_read = obd[7:0];
      CCPR_OFF_OBD_MID: ccpr_read = obd[15:8];
      CCPR_OFF_OBD_HI: ccpr_read = obd[23:16];
      CCPR_OFF_MASK: ccpr_read = msk;
      default: ccpr_read = CCPR_RST_BYTE;
    endcase
  endfunction : ccpr_read

  ccpr_serial_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in({serial_port_select_n, sclk, sdio_in}),
    .sync_out(sync)
  );

  assign sen_n = sync[2];
  assign sclk_s = sync[1];
  assign sdi_s = sync[0];
  assign rise = sclk_s & ~sclk_d_reg;
  assign fall = ~sclk_s & sclk_d_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end

  // serial frame receiver; read bit is shift_reg[15] after 16 bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CCPR_IDLE;
      cnt_reg <= 5'h00;
      shift_reg <= 24'h000000;
    end else begin
      case (state_reg)
        CCPR_IDLE: begin
          cnt_reg <= 5'h00;
          if (!sen_n) begin
            state_reg <= CCPR_SHIFT;
          end
        end
        CCPR_SHIFT: begin
          if (sen_n) begin
            state_reg <= CCPR_IDLE;
          end else if (rise) begin
            shift_reg <= {shift_reg[22:0], sdi_s};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == CCPR_FRAME_BITS - 5'h01) begin
              state_reg <= CCPR_DONE;
            end
          end
        end
        CCPR_DONE: begin
          if (sen_n) begin
            state_reg <= CCPR_IDLE;
          end
        end
        default: state_reg <= CCPR_IDLE;
      endcase
    end
  end

  // write strobe one cycle at frame end, write frames only
  assign wr_stb = (state_reg == CCPR_SHIFT) && rise && !sen_n && (cnt_reg == CCPR_FRAME_BITS - 5'h01)
                  && !shift_reg[22] && (shift_reg[21:19] == 3'h0);
  wire [11:0] wr_addr = shift_reg[18:7];
  wire [7:0] wr_data = {shift_reg[6:0], sdi_s};
  assign soft_rst = wr_stb && (wr_addr == CCPR_OFF_SOFT_RESET) && wr_data[CCPR_BIT_RESET];

  assign rd_byte = ccpr_read(shift_reg[11:0], soft_reset_ctrl_reg, output_interface_ctrl_reg, power_down_ctrl_reg,
                             obd_reg, mask_reg);

  // read data loaded after the address phase, shifted out msb first on falling edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      if (state_reg == CCPR_SHIFT && cnt_reg == CCPR_ADDR_BITS && shift_reg[15] && shift_reg[14:12] == 3'h0) begin
        if (fall) begin
          rdata_reg <= rd_byte;
          sdio_out <= rd_byte[7];
          sdio_oe <= 1'b1;
        end
      end else if (state_reg == CCPR_SHIFT && sdio_oe) begin
        if (fall) begin
          rdata_reg <= {rdata_reg[6:0], 1'b0};
          sdio_out <= rdata_reg[6];
        end
      end else begin
        sdio_oe <= 1'b0;
        sdio_out <= 1'b0;
      end
    end
  end

  // set only for the restore cycle, then self clears; a frame is far longer, so reads see zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_reset_ctrl_reg <= CCPR_RST_BYTE;
    end else begin
      soft_reset_ctrl_reg <= soft_rst ? CCPR_MASK_SOFT_RESET : CCPR_RST_BYTE;
    end
  end

  // register bank, soft reset restores defaults
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_interface_ctrl_reg <= CCPR_RST_BYTE;
      power_down_ctrl_reg <= CCPR_RST_BYTE;
      obd_reg <= CCPR_RST_OBD;
      mask_reg <= CCPR_RST_BYTE;
    end else if (soft_rst) begin
      output_interface_ctrl_reg <= CCPR_RST_BYTE;
      power_down_ctrl_reg <= CCPR_RST_BYTE;
      obd_reg <= CCPR_RST_OBD;
      mask_reg <= CCPR_RST_BYTE;
    end else if (wr_stb) begin
      case (wr_addr)
        CCPR_OFF_IFACE: output_interface_ctrl_reg <= wr_data & CCPR_MASK_IFACE;
        CCPR_OFF_PDN: power_down_ctrl_reg <= wr_data & CCPR_MASK_PDN;
        CCPR_OFF_OBD_LO: obd_reg[7:0] <= wr_data;
        CCPR_OFF_OBD_MID: obd_reg[15:8] <= wr_data;
        CCPR_OFF_OBD_HI: obd_reg[23:16] <= wr_data;
        CCPR_OFF_MASK: mask_reg <= wr_data & CCPR_MASK_MASKREG;
        default: ;
      endcase
    end
  end

  // fuse load: active mapping taken from register only on command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      map_active_reg <= 3'h0;
      mode_fuse_reg <= 3'h0;
    end else if (soft_rst || state_reg == CCPR_IDLE && map_active_reg == 3'h0) begin
      // fuses caught after reset release, register field still reads 000
      map_active_reg <= fuse_bit_mapping;
      mode_fuse_reg <= fuse_iface_mode;
    end else if (wr_stb && wr_addr == CCPR_OFF_FUSE && wr_data[CCPR_BIT_FUSE_LD]) begin
      // an unwritten 000 field keeps the fuse mapping
      if (output_interface_ctrl_reg[CCPR_BIT_MAP_HI:CCPR_BIT_MAP_LO] != 3'h0) begin
        map_active_reg <= output_interface_ctrl_reg[CCPR_BIT_MAP_HI:CCPR_BIT_MAP_LO];
      end else begin
        map_active_reg <= fuse_bit_mapping;
      end
    end
  end

  // effective outputs, all registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iface_bit_mapping <= 3'h0;
      iface_mode_select <= 3'h0;
      sample_clock_buffer_off <= 1'b0;
      reference_gain_amp_off <= 1'b0;
      channel_a_off <= 1'b0;
      channel_b_off <= 1'b0;
      bandgap_off <= 1'b0;
      output_buffer_disable <= CCPR_RST_OBD;
    end else begin
      iface_bit_mapping <= map_active_reg;
      iface_mode_select <= output_interface_ctrl_reg[CCPR_BIT_OVR]
                           ? output_interface_ctrl_reg[CCPR_BIT_SEL_HI:0] : mode_fuse_reg;
      sample_clock_buffer_off <= power_down_ctrl_reg[CCPR_BIT_CLKBUF]
                                 | (power_down_ctrl_reg[CCPR_BIT_GLOBAL] & ~mask_reg[CCPR_BIT_KEEP_CLK]);
      reference_gain_amp_off <= power_down_ctrl_reg[CCPR_BIT_REFAMP]
                                | (power_down_ctrl_reg[CCPR_BIT_GLOBAL] & ~mask_reg[CCPR_BIT_KEEP_REF]);
      channel_a_off <= power_down_ctrl_reg[CCPR_BIT_CHA] | power_down_ctrl_reg[CCPR_BIT_GLOBAL];
      channel_b_off <= power_down_ctrl_reg[CCPR_BIT_CHB] | power_down_ctrl_reg[CCPR_BIT_GLOBAL];
      bandgap_off <= power_down_ctrl_reg[CCPR_BIT_GLOBAL] & mask_reg[CCPR_BIT_BG_OFF];
      output_buffer_disable <= obd_reg;
    end
  end

  chk_soft_reset_clear: assert property (@(posedge clk) disable iff (!rstn)
    soft_rst |=> ##1 (power_down_ctrl_reg == 8'h00 && soft_reset_ctrl_reg == 8'h00))
    else $error("soft reset did not restore defaults");
  chk_reset_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
    soft_reset_ctrl_reg[0] |=> soft_reset_ctrl_reg == 8'h00)
    else $error("soft reset bit reads one");
  chk_override_mode: assert property (@(posedge clk) disable iff (!rstn)
    output_interface_ctrl_reg[3] |=>
    iface_mode_select == $past(output_interface_ctrl_reg[2:0]))
    else $error("override mode not applied");
  chk_clkbuf_off: assert property (@(posedge clk) disable iff (!rstn)
    $stable(power_down_ctrl_reg) && power_down_ctrl_reg[5] |=> sample_clock_buffer_off)
    else $error("clock buffer not off");
  chk_refamp_off: assert property (@(posedge clk) disable iff (!rstn)
    $stable(power_down_ctrl_reg) && power_down_ctrl_reg[4] |=> reference_gain_amp_off)
    else $error("ref amp not off");
  chk_cha_off: assert property (@(posedge clk) disable iff (!rstn)
    $stable(power_down_ctrl_reg) && power_down_ctrl_reg[2] |=> channel_a_off)
    else $error("channel a not off");
  chk_chb_off: assert property (@(posedge clk) disable iff (!rstn)
    $stable(power_down_ctrl_reg) && power_down_ctrl_reg[1] |=> channel_b_off)
    else $error("channel b not off");
  chk_mask_keeps_clk: assert property (@(posedge clk) disable iff (!rstn)
    $stable(power_down_ctrl_reg) && $stable(mask_reg) && power_down_ctrl_reg == 8'h01 && mask_reg[3]
    |=> !sample_clock_buffer_off && channel_a_off)
    else $error("mask not honoured");
  chk_obd_follow: assert property (@(posedge clk) disable iff (!rstn)
    output_buffer_disable == $past(obd_reg))
    else $error("buffer disable mismatch");
endmodule : ccpr_regs
`default_nettype wire

// *** tb/ccpr_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ccpr_host_model (
  // clock
  input wire logic clk,
  // serial port
  output logic serial_port_select_n,
  output logic sclk,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  initial begin
    serial_port_select_n = 1'b1;
    sclk = 1'b0;
    sdio_in = 1'b0;
  end
  // half periods of 5 clk leave margin over the 3-clk minimum
  task automatic xfer(input logic rd, input logic [11:0] addr, input logic [7:0] wd, output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, 3'h0, addr, rd ? 8'h00 : wd};
    rdata = 8'h00;
    @(negedge clk);
    serial_port_select_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdio_in = frame[i];
      repeat (5) @(negedge clk);
      if (i < 8) begin
        // an undriven line reads unknown, so a missing enable fails the compare
        rdata[i] = sdio_oe ? sdio_out : 1'bx;
      end
      sclk = 1'b1;
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (5) @(negedge clk);
    serial_port_select_n = 1'b1;
    // released line must not keep the last bit
    sdio_in = ~frame[0];
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : ccpr_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ccpr_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [4:0] pwr;
  } ccpr_row_t;
  localparam logic [2:0] FUSE_MAP = 3'h3;
  localparam logic [2:0] FUSE_MODE = 3'h5;
  logic clk, rstn, sel_n, sclk, sdi, sdo, sdo_oe;
  logic [2:0] map_q, mode_q;
  logic clk_off, ref_off, a_off, b_off, bg_off;
  logic [23:0] obd;
  logic [7:0] rv;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [11:0] regs [6] = '{12'h000, 12'h007, 12'h008, 12'h00a, 12'h00b, 12'h00c};
  logic [2:0] maps [5] = '{CCPR_MAP_2W_18_14, CCPR_MAP_2W_16, CCPR_MAP_1W, CCPR_MAP_HALF, CCPR_MAP_DDR};
  logic [2:0] modes [5] = '{CCPR_MODE_DDR, CCPR_MODE_2W, CCPR_MODE_1W, CCPR_MODE_HALF, CCPR_MODE_DDR};
  // pwr: clock buffer, reference amp, channel a, channel b, bandgap
  ccpr_row_t rows [12] = '{
    '{12'h008, 8'h36, 8'h36, 5'h1e},
    '{12'h008, 8'h00, 8'h00, 5'h00},
    '{12'h008, 8'h04, 8'h04, 5'h04},
    '{12'h008, 8'h02, 8'h02, 5'h02},
    '{12'h008, 8'h01, 8'h01, 5'h1e},
    '{12'h00d, 8'h0e, 8'h0e, 5'h07},
    '{12'h00d, 8'h08, 8'h08, 5'h0e},
    '{12'h008, 8'h00, 8'h00, 5'h00},
    '{12'h00a, 8'h23, 8'h23, 5'h00},
    '{12'h00b, 8'h46, 8'h46, 5'h00},
    '{12'h00c, 8'hf0, 8'hf0, 5'h00},
    '{12'h005, 8'h5a, 8'h00, 5'h00}};

  ccpr_regs ccpr_regs_i (.clk(clk), .rstn(rstn), .serial_port_select_n(sel_n), .sclk(sclk),
    .sdio_in(sdi), .sdio_out(sdo), .sdio_oe(sdo_oe), .fuse_bit_mapping(FUSE_MAP),
    .fuse_iface_mode(FUSE_MODE), .iface_bit_mapping(map_q), .iface_mode_select(mode_q),
    .sample_clock_buffer_off(clk_off), .reference_gain_amp_off(ref_off), .channel_a_off(a_off),
    .channel_b_off(b_off), .bandgap_off(bg_off), .output_buffer_disable(obd));
  ccpr_host_model ccpr_host_model_i (.clk(clk), .serial_port_select_n(sel_n), .sclk(sclk),
    .sdio_in(sdi), .sdio_out(sdo), .sdio_oe(sdo_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // about 40 frames of 250 cycles expected
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check("map fuse", map_q, FUSE_MAP);
    check("mode fuse", mode_q, FUSE_MODE);
    foreach (regs[i]) begin
      ccpr_host_model_i.xfer(1'b1, regs[i], 8'h00, rv);
      check("reset value", rv, 32'h0);
    end
    foreach (rows[i]) begin
      ccpr_host_model_i.xfer(1'b0, rows[i].addr, rows[i].wd, rv);
      ccpr_host_model_i.xfer(1'b1, rows[i].addr, 8'h00, rv);
      check("readback", rv, rows[i].rd);
      check("power", {clk_off, ref_off, a_off, b_off, bg_off}, rows[i].pwr);
    end
    check("buffers", obd, 24'hf04623);
    ccpr_host_model_i.xfer(1'b0, CCPR_OFF_IFACE, 8'h24, rv);
    check("mode no override", mode_q, FUSE_MODE);
    check("map before load", map_q, FUSE_MAP);
    for (int i = 0; i < 5; i++) begin
      ccpr_host_model_i.xfer(1'b0, CCPR_OFF_IFACE, {maps[i], 2'b01, modes[i]}, rv);
      check("mode", mode_q, modes[i]);
      ccpr_host_model_i.xfer(1'b0, CCPR_OFF_FUSE, 8'h01, rv);
      check("mapper", map_q, maps[i]);
    end
    ccpr_host_model_i.xfer(1'b0, CCPR_OFF_PDN, 8'h36, rv);
    ccpr_host_model_i.xfer(1'b0, CCPR_OFF_SOFT_RESET, 8'h01, rv);
    ccpr_host_model_i.xfer(1'b1, CCPR_OFF_SOFT_RESET, 8'h00, rv);
    check("reset bit", rv, 32'h0);
    check("power after reset", {clk_off, ref_off, a_off, b_off, bg_off}, 32'h0);
    check("buffers after reset", obd, 32'h0);
    check("map after reset", map_q, FUSE_MAP);
    check("mode after reset", mode_q, FUSE_MODE);
    check("sdio released", sdo_oe, 32'h0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
